// ### rtl/fdc_dev.sv
// Purpose: flash driver control and status register bank
// Assumes: link and pin inputs asynchronous; event inputs on clk_sys_in
// Notes:   link sampled on synchronised rising edge of lk_clk
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module fdc_dev
  import fdc_pkg::*;
#(
  parameter int PWM_PERIOD = PWM_PERIOD_CYC
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  fdc_link_if.dev         lk,
  input  wire logic       strobe_in,
  input  wire logic       uv_event_in,
  input  wire logic       timeout_event_in,
  input  wire logic       overtemp_event_in,
  input  wire logic       short_event_in,
  input  wire logic       ovp_event_in,
  input  wire logic       converter_running_in,
  input  wire logic       sink_a_cmp_in,
  input  wire logic       sink_b_cmp_in,
  input  wire logic [7:0] present_level_in,
  output logic [7:0]      sink_a_level_out,
  output logic [7:0]      sink_b_level_out,
  output logic [7:0]      supply_cfg_out,
  output logic [7:0]      duration_cfg_out,
  output logic [1:0]      mode_out,
  output logic            outputs_on_out,
  output logic            flash_active_out,
  output logic            pwm_gate_out,
  output logic            pulse_skip_allow_out,
  output logic            balance_en_out,
  output logic            uplift_out
);
  localparam int SYW = 22;

  typedef struct packed {
    logic [SYW-1:0] sy1;
    logic [SYW-1:0] sy2;
    logic           clk_d;
    logic           sel_d;
    logic           str_d;
    logic [7:0]     sink_a;
    logic [7:0]     sink_b;
    logic [7:0]     supply;
    logic [7:0]     dur;
    logic [7:0]     ctrl;
    logic [7:0]     trig;
    logic [7:0]     fault;
    logic [7:0]     dim;
    logic [7:0]     lowest;
    logic [7:0]     present;
    logic [7:0]     uplift;
    logic [7:0]     rdata;
    logic [7:0]     track;
    logic           unlocked;
    logic           clr_pend;
    logic           flash;
    logic           done;
    logic           uv_seen;
    logic           skip_ok;
  } fdc_dev_st_t;

  fdc_dev_st_t st;
  fdc_dev_st_t next_st;

  logic       l_clk;
  logic       l_sel;
  logic       l_wr;
  logic [7:0] l_addr;
  logic [7:0] l_wd;
  logic       l_str;
  logic       l_ca;
  logic       l_cb;
  logic       access;
  logic       flash_mode;
  logic [7:0] wmask;
  logic [7:0] rd;
  logic [7:0] evt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.sy1 = {lk.lk_clk, lk.lk_sel, lk.lk_wr, lk.lk_addr, lk.lk_wdata,
                   strobe_in, sink_a_cmp_in, sink_b_cmp_in};
    next_st.sy2 = st.sy1;
    {l_clk, l_sel, l_wr, l_addr, l_wd, l_str, l_ca, l_cb} = st.sy2;
    next_st.clk_d = l_clk;
    next_st.sel_d = l_sel;
    next_st.str_d = l_str;
    access = l_clk && !st.clk_d && l_sel;
    wmask = fdc_wmask(l_addr);

    case (l_addr)
      A_ID:      rd = CHIP_ID;
      A_SINK_A:  rd = st.sink_a;
      A_SINK_B:  rd = st.sink_b;
      A_SUPPLY:  rd = st.supply;
      A_DUR:     rd = st.dur;
      A_CTRL:    rd = st.ctrl;
      A_TRIG:    rd = st.trig;
      A_FAULT:   rd = st.fault;
      A_DIM:     rd = st.dim;
      A_LOWEST:  rd = st.lowest;
      A_PRESENT: rd = st.present;
      A_UPLIFT:  rd = st.unlocked ? st.uplift : RST_ZERO;
      default:   rd = RST_ZERO;
    endcase

    evt = RST_ZERO;
    evt[FLT_UV_BIT] = uv_event_in;
    evt[FLT_TO_BIT] = timeout_event_in;
    evt[FLT_OT_BIT] = overtemp_event_in;
    evt[FLT_SH_BIT] = short_event_in;
    evt[FLT_OV_BIT] = ovp_event_in;

    if (st.sel_d && !l_sel) begin
      next_st.clr_pend = 1'b0;
      if (st.clr_pend) begin
        next_st.fault = RST_ZERO;
      end
    end
    next_st.fault = next_st.fault | evt;

    if (access) begin
      next_st.unlocked = 1'b0;
      if (l_wr) begin
        case (l_addr)
          A_SINK_A: next_st.sink_a = l_wd;
          A_SINK_B: next_st.sink_b = l_wd;
          A_SUPPLY: next_st.supply = l_wd;
          A_DUR:    next_st.dur = l_wd;
          A_CTRL:   next_st.ctrl = l_wd & wmask;
          A_TRIG:   next_st.trig = l_wd & wmask;
          A_DIM:    next_st.dim = (st.dim & ~wmask) | (l_wd & wmask);
          A_KEY:    next_st.unlocked = (l_wd == UNLOCK_VALUE);
          A_UPLIFT: begin
            if (st.unlocked) begin
              next_st.uplift = l_wd & wmask;
            end
          end
          default: ;
        endcase
      end else begin
        next_st.rdata = rd;
        if (l_addr == A_FAULT) begin
          next_st.clr_pend = 1'b1;
        end
      end
    end

    if (converter_running_in) begin
      next_st.dim[DIM_AHI_BIT] = l_ca;
      next_st.dim[DIM_BHI_BIT] = l_cb;
    end

    flash_mode = (st.ctrl[1:0] == MODE_FLASH) && st.ctrl[CTRL_ON_BIT];
    if (!flash_mode) begin
      next_st.flash = 1'b0;
      next_st.done = 1'b0;
    end else if (timeout_event_in) begin
      next_st.flash = 1'b0;
      next_st.done = 1'b1;
    end else if (!st.trig[TRIG_EN_BIT]) begin
      next_st.flash = !st.done;
    end else if (st.trig[TRIG_SENSE_BIT]) begin
      next_st.flash = l_str;
    end else if (l_str && !st.str_d) begin
      next_st.flash = 1'b1;
    end

    if (next_st.flash && !st.flash) begin
      next_st.track = 8'hff;
      next_st.uv_seen = 1'b0;
    end else if (st.flash) begin
      if (present_level_in < st.track) begin
        next_st.track = present_level_in;
      end
      if (uv_event_in) begin
        next_st.uv_seen = 1'b1;
      end
      if (!next_st.flash) begin
        next_st.lowest = (st.uv_seen || uv_event_in) ? next_st.track : RST_ZERO;
      end
    end

    next_st.present = present_level_in;

    next_st.skip_ok = !(st.dim[DIM_LOCK_BIT]
                        && (st.ctrl[1:0] == MODE_FLASH || st.ctrl[1:0] == MODE_ASSIST)
                        && st.sink_a >= FIXED_FREQ_MIN && st.sink_b >= FIXED_FREQ_MIN
                        && !st.uplift[UPLIFT_BIT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
      st.sink_a <= RST_SINK;
      st.sink_b <= RST_SINK;
      st.supply <= RST_SUPPLY;
      st.dur <= RST_DUR;
      st.ctrl <= RST_CTRL;
      st.trig <= RST_TRIG;
      st.skip_ok <= 1'b1;
      st.track <= 8'hff;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator pwm
  fdc_pwm #(
    .PERIOD_CYC (PWM_PERIOD)
  ) u_pwm (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .en_in      ((st.ctrl[1:0] == MODE_IND) && st.ctrl[CTRL_ON_BIT]),
    .duty_in    (st.dim[1:0]),
    .gate_out   (pwm_gate_out)
  );

  assign lk.lk_rdata          = st.rdata;
  assign sink_a_level_out     = st.sink_a;
  assign sink_b_level_out     = st.sink_b;
  assign supply_cfg_out       = st.supply;
  assign duration_cfg_out     = st.dur;
  assign mode_out             = st.ctrl[1:0];
  assign outputs_on_out       = st.ctrl[CTRL_ON_BIT];
  assign flash_active_out     = st.flash;
  assign pulse_skip_allow_out = st.skip_ok;
  assign balance_en_out       = st.dim[DIM_BAL_BIT];
  assign uplift_out           = st.uplift[UPLIFT_BIT];
endmodule : fdc_dev
`default_nettype wire

// ### rtl/fdc_pkg.sv
// Purpose: shared constants for the flash driver register bank and its host
// Assumes: 250 MHz system clock on both ends
// Notes:   register map, field positions, timing counts
//
// What this block does
// - trigger sense bit 6: 0 means edge
// - trigger enable bit 7 gates strobe pin
// - fault flags clear after completed fault read
// - fault bit 0 flags undervoltage reduction
// - bit 4 timeout, bit 5 overtemperature
// - bit 6 flags shorted sink pin
// - bit 7 flags converter overvoltage
// - duty field sets indicator pwm duty
// - lock bit clear allows pulse skip
// - lock set, levels high, assist or flash mode, uplift clear: fixed frequency
// - status bits report sink comparator results
// - balance bit enables sink current trimming
// - lowest level report, zero without reduction
// - present level report of sink a
// - host reads reports twice or afterwards
// - unlock key precedes uplift register access
// - unlock covers exactly one following access
// - uplift bit 0 raises all currents
// - host writes zero to reserved bits
// - flash mode triggers from strobe pin when trigger enable bit 7 is set
`default_nettype none
package fdc_pkg;
  localparam logic [7:0] A_ID      = 8'h00;
  localparam logic [7:0] A_SINK_A  = 8'h01;
  localparam logic [7:0] A_SINK_B  = 8'h02;
  localparam logic [7:0] A_SUPPLY  = 8'h04;
  localparam logic [7:0] A_DUR     = 8'h05;
  localparam logic [7:0] A_CTRL    = 8'h06;
  localparam logic [7:0] A_TRIG    = 8'h07;
  localparam logic [7:0] A_FAULT   = 8'h08;
  localparam logic [7:0] A_DIM     = 8'h09;
  localparam logic [7:0] A_LOWEST  = 8'h0e;
  localparam logic [7:0] A_PRESENT = 8'h0f;
  localparam logic [7:0] A_KEY     = 8'h80;
  localparam logic [7:0] A_UPLIFT  = 8'h81;

  localparam logic [7:0] RST_SINK   = 8'h9c;
  localparam logic [7:0] RST_SUPPLY = 8'h2c;
  localparam logic [7:0] RST_DUR    = 8'h23;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_TRIG   = 8'hc0;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  // identification value is arbitrary
  localparam logic [7:0] CHIP_ID    = 8'h5a;

  localparam int TRIG_SENSE_BIT = 6;
  localparam int TRIG_EN_BIT    = 7;
  localparam int FLT_UV_BIT     = 0;
  localparam int FLT_TO_BIT     = 4;
  localparam int FLT_OT_BIT     = 5;
  localparam int FLT_SH_BIT     = 6;
  localparam int FLT_OV_BIT     = 7;
  localparam int DIM_LOCK_BIT   = 2;
  localparam int DIM_AHI_BIT    = 3;
  localparam int DIM_BHI_BIT    = 4;
  localparam int DIM_BAL_BIT    = 5;
  localparam int CTRL_ON_BIT    = 3;
  localparam int UPLIFT_BIT     = 0;

  localparam logic [1:0] MODE_IND    = 2'b01;
  localparam logic [1:0] MODE_ASSIST = 2'b10;
  localparam logic [1:0] MODE_FLASH  = 2'b11;
  localparam logic [7:0] FIXED_FREQ_MIN = 8'h40;
  localparam logic [7:0] UNLOCK_VALUE   = 8'ha1;

  // host apb map
  localparam logic [31:0] HA_CMD  = 32'h0000_0000;
  localparam logic [31:0] HA_STAT = 32'h0000_0004;
  localparam int CMD_WDATA_LSB  = 8;
  localparam int CMD_WR_BIT     = 16;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_RDATA_LSB = 8;

  localparam int CLK_NS        = 4;
  localparam int PWM_HZ        = 31250;
  localparam int PWM_STEPS     = 16;
  localparam int PWM_PERIOD_CYC = 1000000000 / (PWM_HZ * CLK_NS);
  localparam int LINK_NS       = 80;
  localparam int LINK_HALF_CYC = LINK_NS / (2 * CLK_NS);

  // writable bits per register; all others are reserved or read-only
  function automatic logic [7:0] fdc_wmask(input logic [7:0] addr);
    case (addr)
      A_SINK_A, A_SINK_B, A_SUPPLY, A_DUR: fdc_wmask = 8'hff;
      A_CTRL:   fdc_wmask = 8'h1b;
      A_TRIG:   fdc_wmask = 8'hc0;
      A_DIM:    fdc_wmask = 8'h27;
      A_UPLIFT: fdc_wmask = 8'h01;
      A_KEY:    fdc_wmask = 8'hff;
      default:  fdc_wmask = 8'h00;
    endcase
  endfunction : fdc_wmask
endpackage : fdc_pkg
`default_nettype wire

// ### rtl/fdc_link_if.sv
// Purpose: link between host controller and flash driver register bank
// Assumes: host drives clock, select and request; device drives read data
// Notes:   one select frame carries one access
`timescale 1ns/10ps
`default_nettype none
interface fdc_link_if;
  logic       lk_clk;
  logic       lk_sel;
  logic       lk_wr;
  logic [7:0] lk_addr;
  logic [7:0] lk_wdata;
  logic [7:0] lk_rdata;
  modport host (output lk_clk, lk_sel, lk_wr, lk_addr, lk_wdata, input lk_rdata);
  modport dev  (input lk_clk, lk_sel, lk_wr, lk_addr, lk_wdata, output lk_rdata);
endinterface : fdc_link_if
`default_nettype wire

// ### rtl/fdc_pwm.sv
// Purpose: indicator pwm gate generator
// Assumes: duty code 0..3 gives 1/16..4/16 on-time
// Notes:   gate low whenever disabled
`timescale 1ns/10ps
`default_nettype none
module fdc_pwm
  import fdc_pkg::*;
#(
  parameter int PERIOD_CYC = PWM_PERIOD_CYC
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  input  wire logic       en_in,
  input  wire logic [1:0] duty_in,
  output logic            gate_out
);
  localparam int CW   = $clog2(PERIOD_CYC);
  localparam int STEP = PERIOD_CYC / PWM_STEPS;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          gate;
  } fdc_pwm_st_t;

  fdc_pwm_st_t st;
  fdc_pwm_st_t next_st;
  logic [CW-1:0] thr;

  always_comb begin
    next_st = st;
    thr = CW'((32'(duty_in) + 32'd1) * STEP);
    if (!en_in || st.cnt == CW'(PERIOD_CYC - 1)) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
    next_st.gate = en_in && (st.cnt < thr);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign gate_out = st.gate;
endmodule : fdc_pwm
`default_nettype wire

// ### rtl/fdc_host.sv
// Purpose: host controller issuing register accesses over the link
// Assumes: apb master on clk_sys_in; device on its own sampling
// Notes:   uplift register accesses get an automatic key frame first
`timescale 1ns/10ps
`default_nettype none
module fdc_host
  import fdc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  fdc_link_if.host         lk
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_HIGH  = 2'b11,
    ST_END   = 2'b10
  } fdc_host_state_t;

  typedef struct packed {
    fdc_host_state_t state;
    logic [7:0]  cnt;
    logic [31:0] prdata;
    logic        pready;
    logic        slverr;
    logic        key_phase;
    logic        busy;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic [7:0]  rdata;
    logic [7:0]  ry1;
    logic [7:0]  ry2;
    logic        lk_clk;
    logic        lk_sel;
    logic        lk_wr;
    logic [7:0]  lk_addr;
    logic [7:0]  lk_wdata;
  } fdc_host_st_t;

  fdc_host_st_t st;
  fdc_host_st_t next_st;
  logic       half_done;
  logic [7:0] c_addr;

  always_comb begin
    next_st = st;
    next_st.ry1 = lk.lk_rdata;
    next_st.ry2 = st.ry1;
    half_done = (st.cnt == 8'(LINK_HALF_CYC - 1));
    next_st.cnt = half_done ? 8'h00 : st.cnt + 8'h01;
    c_addr = pwdata_in[7:0];

    next_st.pready = psel_in && !penable_in;
    next_st.slverr = psel_in && !penable_in && paddr_in != HA_CMD && paddr_in != HA_STAT;
    if (psel_in && !penable_in) begin
      next_st.prdata = '0;
      if (paddr_in == HA_STAT) begin
        next_st.prdata[STAT_BUSY_BIT] = st.busy;
        next_st.prdata[STAT_RDATA_LSB +: 8] = st.rdata;
      end
    end

    unique case (st.state)
      ST_IDLE: begin
        next_st.cnt = 8'h00;
        if (psel_in && penable_in && st.pready && pwrite_in && paddr_in == HA_CMD) begin
          next_st.addr = c_addr;
          next_st.wdata = pwdata_in[CMD_WDATA_LSB +: 8] & fdc_wmask(c_addr);
          next_st.wr = pwdata_in[CMD_WR_BIT];
          next_st.key_phase = (c_addr == A_UPLIFT);
          next_st.busy = 1'b1;
          next_st.lk_sel = 1'b1;
          next_st.lk_addr = (c_addr == A_UPLIFT) ? A_KEY : c_addr;
          next_st.lk_wdata = (c_addr == A_UPLIFT) ? UNLOCK_VALUE : next_st.wdata;
          next_st.lk_wr = (c_addr == A_UPLIFT) ? 1'b1 : pwdata_in[CMD_WR_BIT];
          next_st.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (half_done) begin
          next_st.lk_clk = 1'b1;
          next_st.state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (half_done) begin
          if (!st.key_phase && !st.wr) begin
            next_st.rdata = st.ry2;
          end
          next_st.lk_clk = 1'b0;
          next_st.lk_sel = 1'b0;
          next_st.state = ST_END;
        end
      end
      ST_END: begin
        if (half_done) begin
          if (st.key_phase) begin
            next_st.key_phase = 1'b0;
            next_st.lk_sel = 1'b1;
            next_st.lk_addr = st.addr;
            next_st.lk_wdata = st.wdata;
            next_st.lk_wr = st.wr;
            next_st.state = ST_SETUP;
          end else begin
            next_st.busy = 1'b0;
            next_st.state = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_out  = st.prdata;
  assign pready_out  = st.pready;
  assign pslverr_out = st.slverr;
  assign lk.lk_clk   = st.lk_clk;
  assign lk.lk_sel   = st.lk_sel;
  assign lk.lk_wr    = st.lk_wr;
  assign lk.lk_addr  = st.lk_addr;
  assign lk.lk_wdata = st.lk_wdata;
endmodule : fdc_host
`default_nettype wire

// ### bench/fdc_properties.sv
// Purpose: link frame checks between host and register bank
// Assumes: frame timing as handed over
// Notes:   watches the interface signals only
`timescale 1ns/10ps
`default_nettype none
module fdc_properties
  import fdc_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       rst_b_in,
  input wire logic       lk_clk,
  input wire logic       lk_sel,
  input wire logic       lk_wr,
  input wire logic [7:0] lk_addr,
  input wire logic [7:0] lk_wdata,
  input wire logic [7:0] lk_rdata
);
  logic sel_q;
  logic key_seen;

  // remembers whether the last frame opened was a key write
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_q    <= 1'b0;
      key_seen <= 1'b0;
    end else begin
      sel_q <= lk_sel;
      if (lk_sel && !sel_q) begin
        key_seen <= lk_wr && lk_addr == A_KEY && lk_wdata == UNLOCK_VALUE;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  ////////////////////////////////////////////////////////////////////////////
  a_key_before_uplift: assert property (lk_sel && !sel_q && lk_addr == A_UPLIFT |-> key_seen)
    else $error("uplift frame without key frame");
  a_key_then_access: assert property ($fell(lk_sel) && $past(lk_wr) && $past(lk_addr) == A_KEY
    |-> ##[1:20] (lk_sel && lk_addr == A_UPLIFT))
    else $error("key frame not followed by uplift frame");
  a_frame_stable: assert property (lk_sel && sel_q |-> $stable(lk_addr) && $stable(lk_wr) && $stable(lk_wdata))
    else $error("request changed inside frame");
  a_idle_clock_low: assert property (!lk_sel |-> !lk_clk)
    else $error("link clock runs outside frame");
  a_high_phase_len: assert property ($rose(lk_clk) |-> lk_clk [*8] ##[1:4] !lk_clk)
    else $error("link clock high phase length wrong");
  a_reserved_zero: assert property (lk_sel && lk_wr |-> (lk_wdata & ~fdc_wmask(lk_addr)) == 8'h00)
    else $error("reserved bits written nonzero");
  a_key_reads_zero: assert property ($fell(lk_sel) && !$past(lk_wr) && $past(lk_addr) == A_KEY
    |-> lk_rdata == 8'h00)
    else $error("key register read not zero");
  a_uplift_upper_zero: assert property ($fell(lk_sel) && !$past(lk_wr) && $past(lk_addr) == A_UPLIFT
    |-> lk_rdata[7:1] == 7'h00)
    else $error("uplift upper bits not zero");

  c_uplift_write: cover property (lk_sel && !sel_q && lk_wr && lk_addr == A_UPLIFT);
  c_fault_read: cover property ($fell(lk_sel) && $past(lk_addr) == A_FAULT && lk_rdata != 8'h00);
  c_key_frame: cover property (lk_sel && !sel_q && lk_addr == A_KEY);
endmodule : fdc_properties
`default_nettype wire

// ### bench/testbench.sv
// Purpose: end to end bench for host controller and register bank
// Assumes: shortened pwm period
// Notes:   all accesses go through the host over apb
`timescale 1ns/10ps
`default_nettype none
module testbench
  import fdc_pkg::*;
  ;
  localparam int PWM_P = 160;
  localparam int LIMIT = 20000;
  logic        clk_sys_in;
  logic        rst_b_in;
  logic        psel, penable, pwrite, pready, pslverr, last_err;
  logic [31:0] paddr, pwdata, prdata;
  logic        strobe, conv, cmp_a, cmp_b, outs_on, flash, pwm, skip, bal, uplift;
  logic [4:0]  ev;
  logic [7:0]  present, sink_a, sink_b, supply, dur;
  logic [1:0]  mode;
  int          n_mismatch, n_checks, cycles;

  fdc_link_if lk_bus ();
  fdc_host u_fdc_host (
    .clk_sys_in (clk_sys_in), .rst_b_in (rst_b_in), .psel_in (psel), .penable_in (penable),
    .pwrite_in (pwrite), .paddr_in (paddr), .pwdata_in (pwdata), .prdata_out (prdata),
    .pready_out (pready), .pslverr_out (pslverr), .lk (lk_bus));
  fdc_dev #(.PWM_PERIOD (PWM_P)) u_fdc_dev (
    .clk_sys_in (clk_sys_in), .rst_b_in (rst_b_in), .lk (lk_bus), .strobe_in (strobe),
    .uv_event_in (ev[0]), .timeout_event_in (ev[1]), .overtemp_event_in (ev[2]),
    .short_event_in (ev[3]), .ovp_event_in (ev[4]), .converter_running_in (conv),
    .sink_a_cmp_in (cmp_a), .sink_b_cmp_in (cmp_b), .present_level_in (present),
    .sink_a_level_out (sink_a), .sink_b_level_out (sink_b), .supply_cfg_out (supply), .duration_cfg_out (dur),
    .mode_out (mode), .outputs_on_out (outs_on), .flash_active_out (flash), .pwm_gate_out (pwm),
    .pulse_skip_allow_out (skip), .balance_en_out (bal), .uplift_out (uplift));
  fdc_properties u_fdc_properties (
    .clk_sys_in (clk_sys_in), .rst_b_in (rst_b_in), .lk_clk (lk_bus.lk_clk), .lk_sel (lk_bus.lk_sel),
    .lk_wr (lk_bus.lk_wr), .lk_addr (lk_bus.lk_addr), .lk_wdata (lk_bus.lk_wdata),
    .lk_rdata (lk_bus.lk_rdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle cycle: next setup never reassigns psel in this step
    @(posedge clk_sys_in);
  endtask : apb

  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [31:0] s;
    apb(1'b1, HA_CMD, {15'h0, wr, d, a}, s);
    do apb(1'b0, HA_STAT, 32'h0, s); while (s[STAT_BUSY_BIT] !== 1'b0);
    r = s[STAT_RDATA_LSB +: 8];
  endtask : acc

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, a, d, r);
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask : rchk

  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    tick(1);
    ev[i] <= 1'b0;
    tick(4);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0]  ad[13];
    logic [7:0]  ex[13];
    logic [31:0] r;
    ad = '{A_ID, A_SINK_A, A_SINK_B, A_SUPPLY, A_DUR, A_CTRL, A_TRIG, A_FAULT, A_DIM, A_LOWEST,
           A_PRESENT, A_KEY, 8'h03};
    ex = '{CHIP_ID, RST_SINK, RST_SINK, RST_SUPPLY, RST_DUR, RST_CTRL, RST_TRIG, RST_ZERO, RST_ZERO,
           RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
    chk(sink_a, RST_SINK);
    chk(sink_b, RST_SINK);
    chk(supply, RST_SUPPLY);
    chk(dur, RST_DUR);
    foreach (ad[i]) rchk(ad[i], ex[i]);
    apb(1'b0, 32'h0000_0010, 32'h0, r);
    chk({7'h0, last_err}, 8'h01);
    wreg(A_ID, 8'hff);
    rchk(A_ID, CHIP_ID);
    wreg(A_SUPPLY, 8'h3d);
    wreg(A_DUR, 8'h7f);
    chk(supply, 8'h3d);
    chk(dur, 8'h7f);
    rchk(A_DUR, 8'h7f);
  endtask : t_reset

  task automatic t_faults;
    int b[5] = '{FLT_UV_BIT, FLT_TO_BIT, FLT_OT_BIT, FLT_SH_BIT, FLT_OV_BIT};
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      rchk(A_FAULT, 8'h01 << b[i]);
      rchk(A_FAULT, 8'h00);
    end
  endtask : t_faults

  task automatic t_trigger;
    present <= 8'h30;
    wreg(A_TRIG, 8'h80);
    wreg(A_CTRL, 8'h0b);
    chk({5'h0, outs_on, mode}, 8'h07);
    chk({7'h0, flash}, 8'h00);
    strobe <= 1'b1;
    tick(8);
    chk({7'h0, flash}, 8'h01);
    strobe <= 1'b0;
    tick(8);
    chk({7'h0, flash}, 8'h01);
    pulse(1);
    chk({7'h0, flash}, 8'h00);
    rchk(A_LOWEST, 8'h00);
    wreg(A_TRIG, 8'hc0);
    wreg(A_CTRL, 8'h00);
    wreg(A_CTRL, 8'h0b);
    strobe <= 1'b1;
    tick(8);
    chk({7'h0, flash}, 8'h01);
    strobe <= 1'b0;
    tick(8);
    chk({7'h0, flash}, 8'h00);
    wreg(A_TRIG, 8'h00);
    wreg(A_CTRL, 8'h00);
    wreg(A_CTRL, 8'h0b);
    chk({7'h0, flash}, 8'h01);
    pulse(0);
    present <= 8'h20;
    tick(2);
    present <= 8'h40;
    tick(2);
    pulse(1);
    rchk(A_LOWEST, 8'h20);
    rchk(A_FAULT, 8'h11);
    wreg(A_CTRL, 8'h00);
  endtask : t_trigger

  task automatic t_pwm;
    int n;
    wreg(A_CTRL, 8'h09);
    for (int c = 0; c < 4; c++) begin
      wreg(A_DIM, 8'(c));
      tick(PWM_P);
      n = 0;
      repeat (PWM_P) begin
        @(posedge clk_sys_in);
        n += int'(pwm === 1'b1);
      end
      chk(8'(n), 8'((c + 1) * PWM_P / 16));
    end
  endtask : t_pwm

  task automatic t_skip;
    wreg(A_CTRL, 8'h0a);
    wreg(A_DIM, 8'h00);
    chk({6'h0, bal, skip}, 8'h01);
    wreg(A_DIM, 8'h24);
    chk({6'h0, bal, skip}, 8'h02);
    wreg(A_UPLIFT, 8'h01);
    chk({6'h0, uplift, skip}, 8'h03);
    rchk(A_UPLIFT, 8'h01);
    wreg(A_UPLIFT, 8'h00);
    wreg(A_SINK_B, 8'h3f);
    chk({6'h0, uplift, skip}, 8'h01);
    wreg(A_SINK_B, 8'h40);
    chk(sink_b, 8'h40);
    chk({7'h0, skip}, 8'h00);
    wreg(A_CTRL, 8'h09);
    chk({7'h0, skip}, 8'h01);
  endtask : t_skip

  task automatic t_status;
    conv    <= 1'b1;
    cmp_a   <= 1'b1;
    present <= 8'h55;
    tick(6);
    rchk(A_DIM, 8'h2c);
    cmp_a <= 1'b0;
    cmp_b <= 1'b1;
    tick(6);
    rchk(A_DIM, 8'h34);
    conv  <= 1'b0;
    cmp_a <= 1'b1;
    cmp_b <= 1'b0;
    tick(6);
    rchk(A_DIM, 8'h34);
    rchk(A_PRESENT, 8'h55);
    rchk(A_PRESENT, 8'h55);
  endtask : t_status

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("MISMATCH t=%0t run too long", $time);
      stop_test();
    end
  end

  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    cycles     = 0;
    rst_b_in   = 1'b0;
    {psel, penable, pwrite, strobe, conv, cmp_a, cmp_b} = 7'h00;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    ev      = 5'h00;
    present = 8'h00;
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    tick(4);
    t_reset();
    t_faults();
    t_trigger();
    t_pwm();
    t_skip();
    t_status();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
